// *** design/fts_sram_core.sv ***
// Access logic of a flow-through burst SRAM: load, burst, byte writes, sleep
// Assumes a synchronous controller on core_clk; sleep_request may be asynchronous
//
// Summary of operation
// - Read starts: enabled, selected, write select high, load
// - Start captures address into address register
// - Read data driven only while output enable low
// - New operation accepted on the very next edge
// - Deselect at load tri-states outputs immediately
// - Burst counter gives four beats per address
// - Burst order pin: low linear, high interleaved
// - Counter touches two low bits, wraps
// - Advance edge ignores chip and write selects
// - Direction captured at load, kept through burst
// - Write starts: enabled, selected, write select low
// - Drivers off during write data, whatever enable
// - Write data taken and committed next edge
// - Only selected byte lanes are written
// - Interleaved: start low pair xor beat index
// - Linear: start low pair plus beat, modulo four
// - Asynchronous sleep request; array contents retained
// - Two cycles to enter and leave sleep
// - Access pending at sleep entry is dropped
// - Clock hold high freezes all state except the sleep synchroniser, and sleep entry still drops a pending access
`timescale 1ns/100ps
`include "fts_defs.svh"
module fts_sram_core #(
  parameter int ADDR_W = `FTS_ADDR_W,
  parameter int LANES  = `FTS_LANES,
  parameter int LANE_W = `FTS_LANE_W
) (
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire logic                     clock_hold_n,
  input  wire logic [ADDR_W-1:0]        address,
  input  wire logic                     chip_select_a_n,
  input  wire logic                     chip_select_b,
  input  wire logic                     chip_select_c_n,
  input  wire logic                     advance_or_load,
  input  wire logic                     write_select_n,
  input  wire logic [LANES-1:0]         byte_lane_select_n,
  input  wire logic                     burst_order,
  input  wire logic                     output_enable_n,
  input  wire logic                     sleep_request,
  input  wire logic [LANES*LANE_W-1:0]  data_in,
  output logic      [LANES*LANE_W-1:0]  data_out,
  output logic                          data_oe,
  output logic                          sleep_active
);

  localparam int DATA_W = LANES * LANE_W;

  // ----------------------------------------------------------------
  // Burst address arithmetic
  // ----------------------------------------------------------------
  function automatic logic [1:0] burst_low(input logic [1:0]         start,
                                           input logic [1:0]         beat,
                                           input fts_pkg::fts_order_t order);
    logic [1:0] sum;
    sum = 2'(start + beat);
    if (order == fts_pkg::FTS_ORDER_INTERLEAVED) begin
      burst_low = start ^ beat;
    end else begin
      burst_low = sum;
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                 sleep_sync;
  logic                 edge_en;
  logic                 sel_all;
  logic                 load;
  logic                 adv;
  fts_pkg::fts_dir_t    dir_r;
  fts_pkg::fts_dir_t    dir_nxt;
  fts_pkg::fts_order_t  order_r;
  fts_pkg::fts_order_t  order_nxt;
  logic [ADDR_W-1:0]    addr_r;
  logic [ADDR_W-1:0]    addr_nxt;
  logic [1:0]           base_r;
  logic [1:0]           beat_r;
  logic [1:0]           beat_nxt;
  logic [LANES-1:0]     lane_n_r;
  logic                 mem_rd_en;
  logic                 mem_wr_en;
  logic [DATA_W-1:0]    mem_rd_data;

  // ----------------------------------------------------------------
  // Sleep request synchroniser
  // ----------------------------------------------------------------
  // two-flop entry and exit
  fts_sync2 u_sleep_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in (sleep_request),
    .sync_out (sleep_sync)
  );

  assign sleep_active = sleep_sync;

  // ----------------------------------------------------------------
  // Edge qualification and command decode
  // ----------------------------------------------------------------
  // hold freezes edge
  assign edge_en = !clock_hold_n && !sleep_sync;
  assign sel_all = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign load    = edge_en && !advance_or_load;
  assign adv     = edge_en && advance_or_load;

  // ----------------------------------------------------------------
  // Next operation, address and burst beat
  // ----------------------------------------------------------------
  always_comb begin
    dir_nxt   = dir_r;
    addr_nxt  = addr_r;
    beat_nxt  = beat_r;
    order_nxt = order_r;
    if (load) begin
      if (sel_all) begin
        dir_nxt   = write_select_n ? fts_pkg::FTS_DIR_READ : fts_pkg::FTS_DIR_WRITE;
        addr_nxt  = address;
        beat_nxt  = `FTS_BEAT_RST;
        order_nxt = burst_order ? fts_pkg::FTS_ORDER_INTERLEAVED
                                : fts_pkg::FTS_ORDER_LINEAR;
      end else begin
        dir_nxt = fts_pkg::FTS_DIR_NONE;
      end
    end else if (adv && (dir_r != fts_pkg::FTS_DIR_NONE)) begin
      beat_nxt       = 2'(beat_r + 2'h1);
      addr_nxt[1:0]  = burst_low(base_r, beat_nxt, order_r);
    end
  end

  // ----------------------------------------------------------------
  // Operation state
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dir_r <= fts_pkg::FTS_DIR_NONE;
    end else if (sleep_sync) begin
      dir_r <= fts_pkg::FTS_DIR_NONE;
    end else if (edge_en) begin
      dir_r <= dir_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Address register and burst counter
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr_r  <= '0;
      base_r  <= `FTS_LOW_RST;
      beat_r  <= `FTS_BEAT_RST;
      order_r <= fts_pkg::FTS_ORDER_LINEAR;
    end else if (edge_en) begin
      addr_r  <= addr_nxt;
      beat_r  <= beat_nxt;
      order_r <= order_nxt;
      if (load && sel_all) begin
        base_r <= address[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte lane selects, sampled with each write beat
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lane_n_r <= '1;
    end else if (edge_en && (dir_nxt == fts_pkg::FTS_DIR_WRITE)) begin
      lane_n_r <= byte_lane_select_n;
    end
  end

  // ----------------------------------------------------------------
  // Array access
  // ----------------------------------------------------------------
  // write commits next edge
  assign mem_wr_en = edge_en && (dir_r == fts_pkg::FTS_DIR_WRITE);
  assign mem_rd_en = edge_en && (dir_nxt == fts_pkg::FTS_DIR_READ);

  fts_mem #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_mem (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .rd_en      (mem_rd_en),
    .rd_addr    (addr_nxt),
    .wr_en      (mem_wr_en),
    .wr_addr    (addr_r),
    .wr_lane_en (~lane_n_r),
    .wr_data    (data_in),
    .rd_data    (mem_rd_data)
  );

  assign data_out = mem_rd_data;

  // ----------------------------------------------------------------
  // Data pin drivers
  // ----------------------------------------------------------------
  // drive only read data
  assign data_oe = (dir_r == fts_pkg::FTS_DIR_READ) && !output_enable_n && !sleep_sync;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_READ_START: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (load && sel_all && write_select_n) |=> (dir_r == fts_pkg::FTS_DIR_READ))
    else $error("read start not recognised");

  AST_WRITE_START: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (load && sel_all && !write_select_n) |=> (dir_r == fts_pkg::FTS_DIR_WRITE) && !data_oe)
    else $error("write start not recognised");

  AST_ADDR_CAPTURE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (load && sel_all) |=> (addr_r == $past(address)))
    else $error("address not captured at load");

  AST_READ_DRIVE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (load && sel_all && write_select_n && !sleep_request) ##1 !output_enable_n
      |-> data_oe && (data_out == mem_rd_data))
    else $error("read data not driven with enable low");

  AST_DESELECT_OFF: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (load && !sel_all) |=> !data_oe)
    else $error("outputs driven after deselect");

  AST_WRITE_NO_DRIVE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (dir_r == fts_pkg::FTS_DIR_WRITE) |-> !data_oe)
    else $error("drivers on during write data");

  AST_WRITE_COMMIT: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (load && sel_all && !write_select_n) ##1 (!clock_hold_n && !sleep_sync)
      |-> mem_wr_en && ($past(address) == addr_r))
    else $error("write not committed on next edge");

  AST_DIR_KEPT: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (adv && (dir_r != fts_pkg::FTS_DIR_NONE)) |=> (dir_r == $past(dir_r)))
    else $error("burst direction changed on advance");

  AST_WRAP_HIGH: assert property (
    @(posedge core_clk) disable iff (!rstn)
    adv |=> (addr_r[ADDR_W-1:2] == $past(addr_r[ADDR_W-1:2])))
    else $error("burst carried into upper address");

  AST_LINEAR_SEQ: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (adv && (dir_r != fts_pkg::FTS_DIR_NONE) && (order_r == fts_pkg::FTS_ORDER_LINEAR))
      |=> (addr_r[1:0] == 2'($past(addr_r[1:0]) + 2'h1)))
    else $error("linear burst sequence wrong");

  AST_INTERLEAVE_SEQ: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (adv && (dir_r != fts_pkg::FTS_DIR_NONE) && (order_r == fts_pkg::FTS_ORDER_INTERLEAVED))
      |=> (addr_r[1:0] == (base_r ^ beat_r)))
    else $error("interleaved burst sequence wrong");

  AST_FOUR_BEATS: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (load && sel_all) ##1 adv[*4] |=> (addr_r == $past(addr_r, 4)))
    else $error("burst did not return to start after four beats");

  AST_HOLD_FREEZE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (clock_hold_n && !sleep_sync) |=> (addr_r == $past(addr_r)) && (dir_r == $past(dir_r))
      && (data_out == $past(data_out)))
    else $error("state changed on held edge");

  AST_SLEEP_ENTER: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(sleep_request) ##1 sleep_request ##1 sleep_request |-> sleep_active)
    else $error("sleep not entered after two cycles");

  AST_SLEEP_EXIT: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $fell(sleep_request) ##1 !sleep_request ##1 !sleep_request |-> !sleep_active)
    else $error("sleep not left after two cycles");

  AST_SLEEP_DROP: assert property (
    @(posedge core_clk) disable iff (!rstn)
    sleep_sync |=> (dir_r == fts_pkg::FTS_DIR_NONE) && !data_oe)
    else $error("access survived sleep entry");

  AST_OE_ASYNC: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (dir_r == fts_pkg::FTS_DIR_READ) && !sleep_sync |-> (data_oe == !output_enable_n))
    else $error("output enable not applied directly");

  AST_ADV_IDLE: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (adv && (dir_r == fts_pkg::FTS_DIR_NONE)) |=> (dir_r == fts_pkg::FTS_DIR_NONE) && $stable(addr_r))
    else $error("advance after deselect started an access");

  AST_BEAT_RESTART: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (load && sel_all) |=> (beat_r == 2'h0) && (base_r == $past(address[1:0])))
    else $error("burst counter not restarted at load");

  AST_ORDER_KEPT: assert property (
    @(posedge core_clk) disable iff (!rstn)
    adv |=> $stable(order_r))
    else $error("burst order changed during burst");

  AST_SLEEP_NO_ACCESS: assert property (
    @(posedge core_clk) disable iff (!rstn)
    sleep_sync |-> !mem_wr_en && !mem_rd_en && !data_oe)
    else $error("array accessed while asleep");

endmodule

// *** design/fts_defs.svh ***
// Constants of the flow-through burst SRAM access block
// Included by the package users; definitions only
`ifndef FTS_DEFS_SVH
`define FTS_DEFS_SVH

// Array geometry
`define FTS_ADDR_W          20
`define FTS_LANES           4
`define FTS_LANE_W          9
`define FTS_BURST_BITS      2
`define FTS_BURST_LEN       4

// Timing, core clock 10 MHz
`define FTS_CLK_PERIOD_NS   100
`define FTS_SLEEP_ENTER_CYC 2
`define FTS_SLEEP_EXIT_CYC  2
`define FTS_SLEEP_RECOV_CYC 2

// Reset values
`define FTS_BEAT_RST        2'h0
`define FTS_LOW_RST         2'h0

`endif

// *** design/fts_pkg.sv ***
// Types shared by the flow-through burst SRAM access block
// No constants here; numbers live in fts_defs.svh
package fts_pkg;

  // Direction of the operation loaded by the last load edge
  typedef enum logic [1:0] {
    FTS_DIR_NONE,
    FTS_DIR_READ,
    FTS_DIR_WRITE
  } fts_dir_t;

  // Burst address sequence
  typedef enum logic {
    FTS_ORDER_LINEAR,
    FTS_ORDER_INTERLEAVED
  } fts_order_t;

endpackage

// *** design/fts_sync2.sv ***
// Two-flop level synchroniser
// Assumes a single destination clock and an asynchronous active-low reset
`timescale 1ns/100ps
module fts_sync2 (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_r;

  // First stage is read only by the second stage
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_r   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// *** design/fts_mem.sv ***
// Byte-lane SRAM array with registered read data
// Assumes one clock; a write and a read of the same word on one edge return new data
`timescale 1ns/100ps
module fts_mem #(
  parameter int ADDR_W = 20,
  parameter int LANES  = 4,
  parameter int LANE_W = 9
) (
  input  wire logic                     core_clk,
  input  wire logic                     rstn,
  input  wire logic                     rd_en,
  input  wire logic [ADDR_W-1:0]        rd_addr,
  input  wire logic                     wr_en,
  input  wire logic [ADDR_W-1:0]        wr_addr,
  input  wire logic [LANES-1:0]         wr_lane_en,
  input  wire logic [LANES*LANE_W-1:0]  wr_data,
  output logic      [LANES*LANE_W-1:0]  rd_data
);

  logic [LANES*LANE_W-1:0] array_q [2**ADDR_W];

  // Array write, lanes masked
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (wr_lane_en[i]) begin
          array_q[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Registered read with same-edge write bypass
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      for (int i = 0; i < LANES; i++) begin
        if (wr_en && wr_lane_en[i] && (wr_addr == rd_addr)) begin
          rd_data[i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
        end else begin
          rd_data[i*LANE_W +: LANE_W] <= array_q[rd_addr][i*LANE_W +: LANE_W];
        end
      end
    end
  end

endmodule

// *** dv/fts_ctrl_model.sv ***
// Controller model for the far side of the flow-through SRAM access block
// Assumes the bench calls step once a cycle, 1 ns after a rising edge
`timescale 1ns/100ps
module fts_ctrl_model #(
  parameter int ADDR_W = 20,
  parameter int LANES  = 4,
  parameter int DATA_W = 36
) (
  input  wire logic              core_clk,
  input  wire logic              data_oe,
  output logic [ADDR_W-1:0]      address,
  output logic                   chip_select_a_n,
  output logic                   chip_select_b,
  output logic                   chip_select_c_n,
  output logic                   advance_or_load,
  output logic                   write_select_n,
  output logic [LANES-1:0]       byte_lane_select_n,
  output logic                   burst_order,
  output logic [DATA_W-1:0]      data_in
);
  initial begin
    address = '0;
    chip_select_a_n = 1'h1;
    chip_select_b = 1'h0;
    chip_select_c_n = 1'h1;
    advance_or_load = 1'h0;
    write_select_n = 1'h1;
    byte_lane_select_n = '1;
    burst_order = 1'h0;
    data_in = '0;
  end

  // One bus cycle; c is {advance, selected, write select}
  task automatic step(input logic [2:0] c, input logic [ADDR_W-1:0] a,
                      input logic [LANES-1:0] b, input logic o, input logic v,
                      input logic [DATA_W-1:0] d);
    advance_or_load = c[2];
    chip_select_a_n = !c[1];
    chip_select_b = c[1];
    chip_select_c_n = !c[1];
    write_select_n = c[0];
    address = a;
    burst_order = o;
    byte_lane_select_n = b;
    // drive only while device is off
    if (v && data_oe !== 1'h1) begin
      data_in = d;
    end else begin
      data_in = ~data_in;
    end
    @(posedge core_clk);
    #1;
  endtask
endmodule

// *** dv/flowthrough_sram_access_burst_sleep_bench.sv ***
// Self-checking bench of the flow-through SRAM access block
// Assumes fts_ctrl_model as controller; inputs move 1 ns after the rising edge
`timescale 1ns/100ps
`include "fts_defs.svh"
module flowthrough_sram_access_burst_sleep_bench;
  localparam int AW = `FTS_ADDR_W;
  localparam int LW = `FTS_LANE_W;
  localparam int DW = `FTS_LANES * LW;
  localparam logic [AW-1:0] BA = 20'h12340;
  localparam logic [AW-1:0] BB = 20'h5A5A4;
  localparam logic [DW-1:0] W1 = 36'h1_2345_6789;
  localparam logic [DW-1:0] W2 = 36'hF_EDCB_A987;
  localparam logic [2:0] LDW = 3'h2;
  localparam logic [2:0] LDR = 3'h3;
  localparam logic [2:0] DS = 3'h1;
  localparam logic [2:0] AVR = 3'h5;
  localparam logic [2:0] AVW = 3'h4;

  logic          core_clk;
  logic          rstn;
  logic          clock_hold_n;
  logic          output_enable_n;
  logic          sleep_request;
  logic [AW-1:0] address;
  logic          chip_select_a_n;
  logic          chip_select_b;
  logic          chip_select_c_n;
  logic          advance_or_load;
  logic          write_select_n;
  logic [3:0]    byte_lane_select_n;
  logic          burst_order;
  logic [DW-1:0] data_in;
  logic [DW-1:0] data_out;
  logic          data_oe;
  logic          sleep_active;
  int            fails;
  int            tests_run;

  initial core_clk = 1'h0;
  always #(`FTS_CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  fts_sram_core i_fts_sram_core (.core_clk, .rstn, .clock_hold_n, .address,
    .chip_select_a_n, .chip_select_b, .chip_select_c_n, .advance_or_load,
    .write_select_n, .byte_lane_select_n, .burst_order, .output_enable_n,
    .sleep_request, .data_in, .data_out, .data_oe, .sleep_active);

  fts_ctrl_model i_fts_ctrl_model (.core_clk, .data_oe, .address, .chip_select_a_n,
    .chip_select_b, .chip_select_c_n, .advance_or_load, .write_select_n,
    .byte_lane_select_n, .burst_order, .data_in);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic st(input logic [2:0] c, input logic [AW-1:0] a, input logic [3:0] b,
                    input logic o, input logic v, input logic [DW-1:0] d);
    i_fts_ctrl_model.step(c, a, b, o, v, d);
  endtask

  task automatic chk_d(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_b(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  function automatic logic [DW-1:0] bd(input int k);
    return 36'h1_1111_1111 * DW'(k + 1);
  endfunction

  function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, input logic [DW-1:0] n,
                                          input logic [3:0] s);
    logic [DW-1:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (!s[i]) r[i*LW +: LW] = n[i*LW +: LW];
    return r;
  endfunction

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_single();
    st(LDW, BA, 4'h0, 1'h0, 1'h0, '0);
    chk_b("write_oe", 1'h0, data_oe);
    st(LDW, BA, 4'hA, 1'h0, 1'h1, W1);
    chk_b("write_oe_b2b", 1'h0, data_oe);
    st(LDR, BA, 4'hF, 1'h0, 1'h1, W2);
    chk_b("read_oe", 1'h1, data_oe);
    chk_d("byte_merge", merge(W1, W2, 4'hA), data_out);
    st(DS, BA, 4'hF, 1'h0, 1'h0, '0);
    chk_b("desel_oe", 1'h0, data_oe);
    st(AVR, '0, 4'hF, 1'h0, 1'h0, '0);
    chk_b("desel_adv_oe", 1'h0, data_oe);
    chk_d("desel_adv_rd", merge(W1, W2, 4'hA), data_out);
    $display("t_single done");
  endtask

  task automatic t_burst();
    st(LDW, BB + 20'h2, 4'h0, 1'h0, 1'h0, '0);
    for (int k = 0; k < 3; k++) st(AVR, '0, 4'h0, 1'h0, 1'h1, bd(k));
    st(LDR, BB + 20'h1, 4'hF, 1'h1, 1'h1, bd(3));
    for (int j = 0; j < 5; j++) begin
      chk_d("burst_rd", bd(((1 ^ j) + 2) & 3), data_out);
      chk_b("burst_dir", 1'h1, data_oe);
      st(AVW, '0, 4'hF, 1'h0, 1'h0, '0);
    end
    st(DS, '0, 4'hF, 1'h0, 1'h0, '0);
    $display("t_burst done");
  endtask

  task automatic t_oe_hold();
    output_enable_n = 1'h1;
    st(LDR, BB + 20'h1, 4'hF, 1'h0, 1'h0, '0);
    chk_b("oe_off", 1'h0, data_oe);
    output_enable_n = 1'h0;
    #1;
    chk_b("oe_comb", 1'h1, data_oe);
    // Same load again so the next stimulus moves on the usual delay
    @(posedge core_clk);
    #1;
    clock_hold_n = 1'h1;
    st(AVR, '0, 4'hF, 1'h0, 1'h0, '0);
    chk_d("hold_rd", bd(3), data_out);
    chk_b("hold_oe", 1'h1, data_oe);
    clock_hold_n = 1'h0;
    st(AVR, '0, 4'hF, 1'h0, 1'h0, '0);
    chk_d("linear_rd", bd(0), data_out);
    st(DS, '0, 4'hF, 1'h0, 1'h0, '0);
    chk_b("desel_oe", 1'h0, data_oe);
    $display("t_oe_hold done");
  endtask

  task automatic t_sleep();
    sleep_request = 1'h1;
    st(DS, '0, 4'hF, 1'h0, 1'h0, '0);
    chk_b("sleep_edge1", 1'h0, sleep_active);
    st(DS, '0, 4'hF, 1'h0, 1'h0, '0);
    chk_b("sleep_edge2", 1'h1, sleep_active);
    chk_b("sleep_oe", 1'h0, data_oe);
    st(DS, '0, 4'hF, 1'h0, 1'h0, '0);
    chk_b("sleep_stay", 1'h1, sleep_active);
    sleep_request = 1'h0;
    st(DS, '0, 4'hF, 1'h0, 1'h0, '0);
    chk_b("wake_edge1", 1'h1, sleep_active);
    st(DS, '0, 4'hF, 1'h0, 1'h0, '0);
    chk_b("wake_edge2", 1'h0, sleep_active);
    repeat (2) st(DS, '0, 4'hF, 1'h0, 1'h0, '0);
    st(LDR, BB + 20'h1, 4'hF, 1'h0, 1'h0, '0);
    chk_d("retained", bd(3), data_out);
    st(DS, '0, 4'hF, 1'h0, 1'h0, '0);
    $display("t_sleep done");
  endtask

  initial begin
    #(`FTS_CLK_PERIOD_NS * 2000);
    fails++;
    test_done();
  end

  initial begin
    fails = 0;
    tests_run = 0;
    rstn = 1'h0;
    clock_hold_n = 1'h0;
    output_enable_n = 1'h0;
    sleep_request = 1'h0;
    repeat (20) @(posedge core_clk);
    #1;
    rstn = 1'h1;
    t_single();
    t_burst();
    t_oe_hold();
    t_sleep();
    test_done();
  end
endmodule
